// *** verilog/adcx_ctrl.sv ***
// Added by the designer: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "adcx_map.svh"
// Operation
// - control-one write aborts, and restarts conversion only with software trigger
// - compare off: flag set each completion
// - compare on: flag set only when true
// - flag cleared by control-one write, low read
// - interrupt when flag set and enabled
// - single mode: one conversion per start
// - continuous mode: back-to-back conversions after start
// - five-bit channel field, codes as listed
// - all-ones channel powers off, no extra conversion
// - single mode powers down after completion
// - active bit spans start to completion/abort
// - trigger select: register write or hardware
// - compare enable bit switches compare
// - compare direction: less, or greater-equal
// - high result holds bits nine, eight
// - results kept when compare fails
// - ten-bit high read locks until low read
// - eight-bit mode has no lock
// - resolution change invalidates high result
// - resolution code 00 eight, 10 ten bits
module adcx_ctrl #(
  parameter int RES_W  = 10, // converter result width
  parameter int CHAN_W = 5   // channel select width
) (
  input  wire logic              clk,          // system clock, 50 MHz
  input  wire logic              nrst,         // async reset, active low
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb access phase
  input  wire logic              pwrite,       // apb direction
  input  wire logic [7:0]        paddr,        // apb byte address
  input  wire logic [31:0]       pwdata,       // apb write data
  output logic [31:0]            prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // apb error, unmapped address
  input  wire logic              hardware_trigger_in, // hardware trigger level
  output logic                   conv_start,   // start pulse to converter
  output logic                   conv_abort,   // abort pulse to converter
  output logic [CHAN_W-1:0]      conv_channel, // selected input
  output logic                   conv_power,   // converter powered
  input  wire logic              conv_done,    // converter finished, pulse
  input  wire logic [RES_W-1:0]  conv_data,    // converter result
  output logic                   complete_irq  // conversion-complete interrupt
);

  // elaboration check: the register layout assumes these widths
  if (RES_W != 10 || CHAN_W != 5)
  begin : g_bad_param
    $error("adcx_ctrl supports only RES_W=10 and CHAN_W=5");
  end

  // sequencer state
  adcx_pkg::adcx_state_t state_reg;  // current state
  adcx_pkg::adcx_state_t state_next; // next state

  // first status/control register
  logic              conversion_complete_flag_reg;  // sticky complete flag
  logic              conversion_complete_flag_next;
  logic              complete_irq_enable_reg;       // interrupt enable
  logic              complete_irq_enable_next;
  logic              continuous_conversion_enable_reg; // continuous mode
  logic              continuous_conversion_enable_next;
  logic [CHAN_W-1:0] channel_select_reg;            // input select
  logic [CHAN_W-1:0] channel_select_next;

  // second status/control register and config
  logic              trigger_source_select_reg;     // 0 software, 1 hardware
  logic              trigger_source_select_next;
  logic              compare_enable_reg;            // compare on
  logic              compare_enable_next;
  logic              compare_greater_equal_reg;     // compare direction
  logic              compare_greater_equal_next;
  logic [1:0]        mode_reg;                      // resolution code
  logic [1:0]        mode_next;
  logic [RES_W-1:0]  cmp_val_reg;                   // compare value
  logic [RES_W-1:0]  cmp_val_next;

  // result path
  logic [RES_W-1:0]  result_reg;   // result_high_bits / result_low_byte
  logic [RES_W-1:0]  result_next;
  logic              lock_reg;     // high read interlock
  logic              lock_next;

  // converter strobes and bus read data
  logic              start_reg;    // start pulse
  logic              start_next;
  logic              abort_reg;    // abort pulse
  logic              abort_next;
  logic              power_reg;    // converter power
  logic              power_next;
  logic [31:0]       prdata_reg;   // read data captured at setup
  logic [31:0]       prdata_next;

  // decoded bus events
  logic              wr_acc;       // write access edge
  logic              rd_acc;       // read access edge
  logic              sc1_wr;       // control-one written
  logic              cfg_wr;       // config written
  logic              res_low_rd;   // low result read
  logic              res_high_rd;  // high result read
  logic              mapped;       // address decodes to a register
  logic              trig_rise;    // synced trigger edge
  logic              ten_bit;      // ten-bit mode active
  logic              done_acc;     // completion of the running conversion
  logic              cmp_true;     // compare condition
  logic              res_ok;       // result passes the compare gate
  logic [RES_W-1:0]  cmp_a;        // result as compared
  logic [RES_W-1:0]  cmp_b;        // compare value as compared
  logic [CHAN_W-1:0] wr_chan;      // channel in the write data

  // trigger synchroniser, the only path from the trigger pin
  adcx_trig_sync u_trig (
    .clk       (clk),
    .nrst      (nrst),
    .trig_in   (hardware_trigger_in),
    .trig_rise (trig_rise)
  );

  // address decode
  always_comb
  begin
    case (paddr)
      `ADCX_OFF_SC1, `ADCX_OFF_SC2, `ADCX_OFF_RES_HIGH,
      `ADCX_OFF_RES_LOW, `ADCX_OFF_CMP_VAL, `ADCX_OFF_CFG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // bus events are taken at the access edge only
  assign wr_acc      = psel & penable & pwrite;
  assign rd_acc      = psel & penable & ~pwrite;
  assign sc1_wr      = wr_acc & (paddr == `ADCX_OFF_SC1);
  assign cfg_wr      = wr_acc & (paddr == `ADCX_OFF_CFG);
  assign res_low_rd  = rd_acc & (paddr == `ADCX_OFF_RES_LOW);
  assign res_high_rd = rd_acc & (paddr == `ADCX_OFF_RES_HIGH);
  assign wr_chan     = pwdata[`ADCX_SC1_CHAN_HI:`ADCX_SC1_CHAN_LO];
  assign ten_bit     = (mode_reg == `ADCX_MODE_10BIT);

  // a write to control-one wins over a completion in the same cycle
  assign done_acc = conv_done & (state_reg == adcx_pkg::ST_CONV) & ~sc1_wr;

  // compare: eight-bit mode looks at the low byte only
  always_comb
  begin
    if (ten_bit)
    begin
      cmp_a = conv_data;
      cmp_b = cmp_val_reg;
    end
    else
    begin
      cmp_a = {2'h0, conv_data[7:0]};
      cmp_b = {2'h0, cmp_val_reg[7:0]};
    end
    cmp_true = compare_greater_equal_reg ? (cmp_a >= cmp_b) : (cmp_a < cmp_b);
  end
  assign res_ok = ~compare_enable_reg | cmp_true;

  // control registers written by software
  always_comb
  begin
    complete_irq_enable_next          = complete_irq_enable_reg;
    continuous_conversion_enable_next = continuous_conversion_enable_reg;
    channel_select_next               = channel_select_reg;
    trigger_source_select_next        = trigger_source_select_reg;
    compare_enable_next               = compare_enable_reg;
    compare_greater_equal_next        = compare_greater_equal_reg;
    mode_next                         = mode_reg;
    cmp_val_next                      = cmp_val_reg;
    if (sc1_wr)
    begin
      // channel codes pass unchanged to the converter mux
      complete_irq_enable_next          = pwdata[`ADCX_SC1_IRQ_EN];
      continuous_conversion_enable_next = pwdata[`ADCX_SC1_CONT];
      channel_select_next               = wr_chan;
    end
    if (wr_acc && paddr == `ADCX_OFF_SC2)
    begin
      // active bit and reserved bits are not stored
      trigger_source_select_next = pwdata[`ADCX_SC2_TRIG_SEL];
      compare_enable_next        = pwdata[`ADCX_SC2_CMP_EN];
      compare_greater_equal_next = pwdata[`ADCX_SC2_CMP_GE];
    end
    if (wr_acc && paddr == `ADCX_OFF_CMP_VAL)
    begin
      cmp_val_next = pwdata[RES_W-1:0];
    end
    if (cfg_wr)
    begin
      mode_next = pwdata[`ADCX_CFG_MODE_HI:`ADCX_CFG_MODE_LO];
    end
  end

  // sequencer: starts, aborts, continuous restart and power down
  always_comb
  begin
    state_next = state_reg;
    start_next = 1'b0;
    abort_next = 1'b0;
    if (sc1_wr)
    begin
      // any control-one write aborts a running conversion
      abort_next = (state_reg == adcx_pkg::ST_CONV);
      state_next = adcx_pkg::ST_IDLE;
      // all-ones code stops without a further conversion
      if (wr_chan != `ADCX_CHAN_OFF && !trigger_source_select_reg)
      begin
        state_next = adcx_pkg::ST_CONV;
        start_next = 1'b1;
      end
    end
    else if (state_reg == adcx_pkg::ST_IDLE)
    begin
      // hardware start; triggers during a conversion are ignored
      if (trig_rise && trigger_source_select_reg && channel_select_reg != `ADCX_CHAN_OFF)
      begin
        state_next = adcx_pkg::ST_CONV;
        start_next = 1'b1;
      end
    end
    else if (done_acc)
    begin
      if (continuous_conversion_enable_reg && channel_select_reg != `ADCX_CHAN_OFF)
      begin
        start_next = 1'b1; // back-to-back restart
      end
      else
      begin
        state_next = adcx_pkg::ST_IDLE; // single mode drops to low power
      end
    end
    power_next = (state_next == adcx_pkg::ST_CONV);
  end

  // complete flag: a set in the same cycle as a clear wins
  always_comb
  begin
    conversion_complete_flag_next = conversion_complete_flag_reg;
    if (sc1_wr || res_low_rd)
    begin
      conversion_complete_flag_next = 1'b0;
    end
    if (done_acc && res_ok)
    begin
      conversion_complete_flag_next = 1'b1;
    end
  end

  // result transfer with compare gate and ten-bit interlock
  always_comb
  begin
    result_next = result_reg;
    lock_next   = lock_reg;
    if (res_low_rd)
    begin
      lock_next = 1'b0; // low read releases the lock
    end
    if (res_high_rd && ten_bit)
    begin
      lock_next = 1'b1;
    end
    // eight-bit mode never locks, so no stale lock may survive
    if (!ten_bit)
    begin
      lock_next = 1'b0;
    end
    if (done_acc && res_ok && !lock_reg)
    begin
      result_next = ten_bit ? conv_data : {2'h0, conv_data[7:0]};
    end
    // a resolution change throws the held high bits away
    if (cfg_wr && pwdata[`ADCX_CFG_MODE_HI:`ADCX_CFG_MODE_LO] != mode_reg)
    begin
      result_next[RES_W-1:8] = 2'h0;
      lock_next              = 1'b0;
    end
  end

  // read mux, captured in the setup cycle and shown during access
  always_comb
  begin
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        `ADCX_OFF_SC1:      prdata_next = {24'h000000, conversion_complete_flag_reg, complete_irq_enable_reg,
                                           continuous_conversion_enable_reg, channel_select_reg};
        `ADCX_OFF_SC2:      prdata_next = {24'h000000, (state_reg == adcx_pkg::ST_CONV), trigger_source_select_reg,
                                           compare_enable_reg, compare_greater_equal_reg, 4'h0};
        `ADCX_OFF_RES_HIGH: prdata_next = {30'h00000000, result_reg[RES_W-1:8]};
        `ADCX_OFF_RES_LOW:  prdata_next = {24'h000000, result_reg[7:0]};
        `ADCX_OFF_CMP_VAL:  prdata_next = {22'h000000, cmp_val_reg};
        `ADCX_OFF_CFG:      prdata_next = {28'h0000000, mode_reg, 2'h0};
        default:            prdata_next = 32'h00000000;
      endcase
    end
  end

  // all state registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg                        <= adcx_pkg::ST_IDLE;
      conversion_complete_flag_reg     <= 1'b0;
      complete_irq_enable_reg          <= 1'b0;
      continuous_conversion_enable_reg <= 1'b0;
      channel_select_reg               <= `ADCX_RST_CHAN;
      trigger_source_select_reg        <= 1'b0;
      compare_enable_reg               <= 1'b0;
      compare_greater_equal_reg        <= 1'b0;
      mode_reg                         <= `ADCX_RST_MODE;
      cmp_val_reg                      <= '0;
      result_reg                       <= '0;
      lock_reg                         <= 1'b0;
      start_reg                        <= 1'b0;
      abort_reg                        <= 1'b0;
      power_reg                        <= 1'b0;
      prdata_reg                       <= 32'h00000000;
    end
    else
    begin
      state_reg                        <= state_next;
      conversion_complete_flag_reg     <= conversion_complete_flag_next;
      complete_irq_enable_reg          <= complete_irq_enable_next;
      continuous_conversion_enable_reg <= continuous_conversion_enable_next;
      channel_select_reg               <= channel_select_next;
      trigger_source_select_reg        <= trigger_source_select_next;
      compare_enable_reg               <= compare_enable_next;
      compare_greater_equal_reg        <= compare_greater_equal_next;
      mode_reg                         <= mode_next;
      cmp_val_reg                      <= cmp_val_next;
      result_reg                       <= result_next;
      lock_reg                         <= lock_next;
      start_reg                        <= start_next;
      abort_reg                        <= abort_next;
      power_reg                        <= power_next;
      prdata_reg                       <= prdata_next;
    end
  end

  // outputs; the slave never inserts wait states
  assign prdata       = prdata_reg;
  assign pready       = 1'b1;
  assign pslverr      = psel & penable & ~mapped;
  assign conv_start   = start_reg;
  assign conv_abort   = abort_reg;
  assign conv_channel = channel_select_reg;
  assign conv_power   = power_reg;
  assign complete_irq = conversion_complete_flag_reg & complete_irq_enable_reg;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  sequence s_sw_start;
    sc1_wr && wr_chan != `ADCX_CHAN_OFF && !trigger_source_select_reg;
  endsequence
  sequence s_started;
    start_reg && state_reg == adcx_pkg::ST_CONV && power_reg;
  endsequence

  a_sw_write_start: assert property (s_sw_start |=> s_started)
    else $error("software write did not start a conversion");
  a_abort_on_write: assert property (sc1_wr && state_reg == adcx_pkg::ST_CONV |=> abort_reg)
    else $error("write during conversion did not abort");
  a_off_no_start: assert property (sc1_wr && wr_chan == `ADCX_CHAN_OFF |=> !start_reg && !power_reg)
    else $error("disable code started a conversion");
  a_flag_on_done: assert property (done_acc && !compare_enable_reg |=> conversion_complete_flag_reg)
    else $error("complete flag not set after conversion");
  a_flag_cmp_gate: assert property (done_acc && compare_enable_reg && !cmp_true && !conversion_complete_flag_reg
                                    |=> !conversion_complete_flag_reg)
    else $error("flag set though compare was false");
  a_flag_clear: assert property (sc1_wr && !done_acc |=> !conversion_complete_flag_reg)
    else $error("control write did not clear flag");
  a_irq_on_flag: assert property (done_acc && res_ok && complete_irq_enable_reg |=> complete_irq)
    else $error("interrupt missing for new flag");
  a_single_idle: assert property (done_acc && !continuous_conversion_enable_reg |=> state_reg == adcx_pkg::ST_IDLE
                                  ##0 !power_reg)
    else $error("single conversion did not power down");
  a_cont_restart: assert property (done_acc && continuous_conversion_enable_reg && channel_select_reg != `ADCX_CHAN_OFF
                                   |=> s_started)
    else $error("continuous mode did not restart");
  a_cmp_keep: assert property (done_acc && compare_enable_reg && !cmp_true && !cfg_wr |=> $stable(result_reg))
    else $error("result changed though compare failed");
  a_lock_keep: assert property (lock_reg && done_acc && !cfg_wr |=> $stable(result_reg))
    else $error("locked result was overwritten");
  a_eight_high_zero: assert property (mode_reg == `ADCX_MODE_8BIT |-> result_reg[RES_W-1:8] == 2'h0)
    else $error("high bits nonzero in eight-bit mode");
  a_active_span: assert property (start_reg |-> state_reg == adcx_pkg::ST_CONV)
    else $error("start without active state");
endmodule : adcx_ctrl

// *** verilog/adcx_map.svh ***
`ifndef ADCX_MAP_SVH
`define ADCX_MAP_SVH

// register byte offsets on the apb bus
`define ADCX_OFF_SC1      8'h00
`define ADCX_OFF_SC2      8'h04
`define ADCX_OFF_RES_HIGH 8'h08
`define ADCX_OFF_RES_LOW  8'h0C
`define ADCX_OFF_CMP_VAL  8'h10
`define ADCX_OFF_CFG      8'h14

// first status/control register fields
`define ADCX_SC1_FLAG     7
`define ADCX_SC1_IRQ_EN   6
`define ADCX_SC1_CONT     5
`define ADCX_SC1_CHAN_HI  4
`define ADCX_SC1_CHAN_LO  0

// second status/control register fields
`define ADCX_SC2_ACTIVE   7
`define ADCX_SC2_TRIG_SEL 6
`define ADCX_SC2_CMP_EN   5
`define ADCX_SC2_CMP_GE   4

// configuration register resolution field
`define ADCX_CFG_MODE_HI  3
`define ADCX_CFG_MODE_LO  2
`define ADCX_MODE_8BIT    2'h0
`define ADCX_MODE_10BIT   2'h2

// channel codes
`define ADCX_CHAN_REF_HIGH 5'h1D
`define ADCX_CHAN_REF_LOW  5'h1E
`define ADCX_CHAN_OFF      5'h1F

// reset values
`define ADCX_RST_CHAN     5'h1F
`define ADCX_RST_MODE     2'h0

`endif

// *** verilog/adcx_pkg.sv ***
package adcx_pkg;
  // conversion sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcx_state_t;
endpackage : adcx_pkg

// *** verilog/adcx_trig_sync.sv ***
`timescale 1ns/1ps
// two-flop synchroniser and rising-edge detector for the hardware trigger
module adcx_trig_sync (
  input  wire logic clk,      // system clock
  input  wire logic nrst,     // async reset, active low
  input  wire logic trig_in,  // raw trigger level
  output logic      trig_rise // one-cycle pulse per assertion
);
  logic meta_reg;  // first stage, read by sync_reg only
  logic sync_reg;  // second stage
  logic last_reg;  // previous synced value for edge detect
  logic meta_next;
  logic sync_next;
  logic last_next;

  // next values
  always_comb
  begin
    meta_next = trig_in;
    sync_next = meta_reg;
    last_next = sync_reg;
  end

  // registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // one start per assertion: only the rising edge counts
  assign trig_rise = sync_reg & ~last_reg;

  a_trig_single_pulse: assert property (@(posedge clk) disable iff (!nrst) trig_rise |=> !trig_rise)
    else $error("trigger edge pulse lasted more than one cycle");
endmodule : adcx_trig_sync

// *** tb/adcx_conv_model.sv ***
`timescale 1ns/1ps
// converter stand-in: answers a start after lat cycles, forgets on abort
module adcx_conv_model (
  input  wire logic       clk,        // system clock
  input  wire logic       nrst,       // async reset, active low
  input  wire logic       conv_start, // begin pulse
  input  wire logic       conv_abort, // drop pulse
  input  wire logic [9:0] res_val,    // result to hand back
  input  wire logic [7:0] lat,        // conversion length, cycles
  output logic            conv_done,  // result ready pulse
  output logic [9:0]      conv_data   // result, valid with done only
);
  logic [7:0] cnt_reg;   // cycles left, zero when idle
  logic [7:0] cnt_next;  // next count
  logic       done_next; // next done
  // count down; restart beats abort, both cancel a pending finish
  always_comb
  begin
    cnt_next  = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    done_next = (cnt_reg == 8'h01) && !conv_abort && !conv_start;
    if (conv_abort)
      cnt_next = 8'h00;
    if (conv_start)
      cnt_next = lat;
  end
  // registers only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_reg   <= 8'h00;
      conv_done <= 1'b0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      conv_done <= done_next;
    end
  end
  // stale data never matches, so a late sample shows up
  assign conv_data = conv_done ? res_val : ~res_val;
endmodule : adcx_conv_model

// *** tb/adcx_ctrl_tb.sv ***
`timescale 1ns/1ps
`include "adcx_map.svh"
module adcx_ctrl_tb;
  logic        clk        = 1'b0;   // 50 MHz
  logic        nrst       = 1'b0;   // reset, active low
  logic        psel       = 1'b0;   // apb select
  logic        penable    = 1'b0;   // apb access
  logic        pwrite     = 1'b0;   // apb direction
  logic [7:0]  paddr      = 8'h00;  // apb address
  logic [31:0] pwdata     = 32'h0;  // apb write data
  logic        hw_trig    = 1'b0;   // hardware trigger level
  logic [9:0]  res_val    = 10'h2AB; // next converter result
  logic [7:0]  lat        = 8'h04;  // converter latency
  logic [31:0] prdata, rdat;        // read data, last taken
  logic        pready, pslverr, rerr, conv_start, conv_abort, conv_power, conv_done, irq;
  logic [4:0]  chan;                // selected channel
  logic [9:0]  conv_data;           // converter result
  int          num_errors = 0;      // mismatches
  int          num_checks = 0;      // comparisons
  int          ns, na;              // start and abort pulses seen
  adcx_ctrl DUT (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hardware_trigger_in(hw_trig),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_channel(chan), .conv_power(conv_power),
    .conv_done(conv_done), .conv_data(conv_data), .complete_irq(irq));
  adcx_conv_model conv (.clk(clk), .nrst(nrst), .conv_start(conv_start), .conv_abort(conv_abort),
    .res_val(res_val), .lat(lat), .conv_done(conv_done), .conv_data(conv_data));
  // free-running clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; an idle edge first so no signal is set twice at once
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      num_errors++;
      tally_and_finish;
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  // wait for the done pulse, bounded, then let the block take it
  task automatic wait_done;
    int n;
    n = 0;
    while (conv_done !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
    end
    if (conv_done !== 1'b1)
    begin
      num_errors++;
      tally_and_finish;
    end
    @(posedge clk);
  endtask : wait_done
  task automatic count(input int cyc);
    ns = 0;
    na = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      ns += int'(conv_start === 1'b1);
      na += int'(conv_abort === 1'b1);
    end
  endtask : count
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    bus(0, `ADCX_OFF_SC1, 0);
    chk("sc1", rdat, 32'h1F);
    bus(0, 8'h40, 0);
    chk("err", rerr, 1'b1);
    $display("test reset and map done");
    bus(1, `ADCX_OFF_CFG, 32'h08);
    bus(1, `ADCX_OFF_SC1, 32'h43);
    wait_done;
    chk("irq", irq, 1'b1);
    chk("power", conv_power, 1'b0);
    chk("chan", chan, 32'h03);
    bus(0, `ADCX_OFF_SC1, 0);
    chk("sc1", rdat, 32'hC3);
    bus(0, `ADCX_OFF_SC2, 0);
    chk("sc2", rdat, 32'h00);
    count(10);
    chk("starts", ns, 0);
    bus(0, `ADCX_OFF_RES_HIGH, 0);
    chk("high", rdat, 32'h2);
    res_val <= 10'h1CD;
    bus(1, `ADCX_OFF_SC1, 32'h03);
    wait_done;
    bus(0, `ADCX_OFF_RES_LOW, 0);
    chk("low", rdat, 32'hAB);
    bus(0, `ADCX_OFF_SC1, 0);
    chk("sc1", rdat, 32'h03);
    $display("test single and lock done");
    bus(1, `ADCX_OFF_CMP_VAL, 32'h100);
    bus(1, `ADCX_OFF_SC2, 32'h20);
    res_val <= 10'h3F0;
    bus(1, `ADCX_OFF_SC1, 32'h03);
    wait_done;
    bus(0, `ADCX_OFF_RES_LOW, 0);
    chk("low", rdat, 32'hAB);
    bus(0, `ADCX_OFF_SC1, 0);
    chk("sc1", rdat, 32'h03);
    bus(1, `ADCX_OFF_SC2, 32'h30);
    bus(1, `ADCX_OFF_SC1, 32'h03);
    wait_done;
    bus(0, `ADCX_OFF_SC1, 0);
    chk("sc1", rdat, 32'h83);
    bus(0, `ADCX_OFF_RES_LOW, 0);
    chk("low", rdat, 32'hF0);
    bus(1, `ADCX_OFF_SC2, 0);
    $display("test compare done");
    bus(1, `ADCX_OFF_CFG, 0);
    bus(0, `ADCX_OFF_RES_HIGH, 0);
    chk("high", rdat, 32'h0);
    res_val <= 10'h0C6;
    bus(1, `ADCX_OFF_SC1, 32'h03);
    wait_done;
    bus(0, `ADCX_OFF_RES_LOW, 0);
    chk("low", rdat, 32'hC6);
    $display("test eight bit done");
    bus(1, `ADCX_OFF_SC1, 32'h23);
    count(40);
    chk("many", ns >= 3, 1'b1);
    bus(1, `ADCX_OFF_SC1, 32'h3F);
    count(30);
    chk("starts", ns, 0);
    chk("power", conv_power, 1'b0);
    lat <= 8'h3C;
    bus(1, `ADCX_OFF_SC1, 32'h03);
    bus(0, `ADCX_OFF_SC2, 0);
    chk("active", rdat, 32'h80);
    bus(1, `ADCX_OFF_SC1, 32'h03);
    count(3);
    chk("abort", na * 2 + ns, 3);
    wait_done;
    $display("test continuous and abort done");
    lat <= 8'h04;
    bus(1, `ADCX_OFF_SC2, 32'h40);
    bus(1, `ADCX_OFF_SC1, 32'h02);
    count(10);
    chk("starts", ns, 0);
    hw_trig <= 1'b1;
    count(20);
    chk("starts", ns, 1);
    hw_trig <= 1'b0;
    bus(0, `ADCX_OFF_SC1, 0);
    chk("sc1", rdat, 32'h82);
    $display("test hardware trigger done");
    tally_and_finish;
  end
endmodule : adcx_ctrl_tb
